/* inc/fpm_pkg.sv */
// package: register map, field positions and reset values for the fault pin mask block
package fpm_pkg;
  localparam logic [7:0] ADDR_RB_CFG   = 8'h26;
  localparam logic [7:0] ADDR_MASK     = 8'h27;
  localparam logic [7:0] ADDR_FT_STAT  = 8'h2B;
  localparam logic [7:0] RST_RB_CFG    = 8'h0F;
  localparam logic [7:0] RST_MASK      = 8'h00;
  localparam logic [7:0] RB_CFG_WMASK  = 8'h0F;
  localparam logic [7:0] ZERO8         = 8'h00;
  localparam logic [3:0] ZERO4         = 4'h0;
  localparam int         NUM_CH        = 4;
  localparam int         NUM_CLASS     = 8;
  localparam int         BIT_SPI_ERR   = 7;
  localparam int         BIT_SERIAL_WATCHDOG_ERROR    = 6;
  localparam int         BIT_ILIMIT    = 5;
  localparam int         BIT_RVRS      = 4;
  localparam int         BIT_SHRT_VS   = 3;
  localparam int         BIT_WB_OFF    = 2;
  localparam int         BIT_WB_ON     = 1;
  localparam int         BIT_VS_UV     = 0;
endpackage

/* inc/fpm_stat_if.sv */
// interface: fault events and status between top and status holder
`timescale 1ns/10ps
interface fpm_stat_if;
  logic [7:0] fault_live;
  logic       hold_disable;
  logic       read_clear;
  logic [7:0] status;
  modport top (output fault_live, output hold_disable, output read_clear, input status);
  modport hold (input fault_live, input hold_disable, input read_clear, output status);
endinterface // fpm_stat_if

/* hdl/fpm_status_hold.sv */
// module: per-class fault status, latched or live
`timescale 1ns/10ps
module fpm_status_hold (
  input  wire logic I_MCLK,
  input  wire logic I_NRST,
  fpm_stat_if.hold  sif
);
  logic [7:0] status;
  logic [7:0] next_status;

  always_comb begin
    if (sif.hold_disable) begin
      next_status = sif.fault_live;
    end else if (sif.read_clear) begin
      // a fault present during the read clear survives: set wins
      next_status = sif.fault_live;
    end else begin
      next_status = status | sif.fault_live;
    end
  end

  always_ff @(posedge I_MCLK or negedge I_NRST) begin
    if (!I_NRST) begin
      status <= fpm_pkg::ZERO8;
    end else begin
      status <= next_status;
    end
  end

  assign sif.status = status;

  // a_hold_keeps_bit ...
  a_hold_keeps_bit: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
    (!sif.hold_disable && !sif.read_clear) |=> ((status & $past(status)) == $past(status)))
    else $error("latched fault bit lost without read");
  // a_live_follow ...
  a_live_follow: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
    sif.hold_disable |=> (status == $past(sif.fault_live)))
    else $error("live status does not follow fault");
endmodule // fpm_status_hold

/* hdl/fpm_top.sv */
// module: fault pin masking, reverse block channel config and register access
`timescale 1ns/10ps
module fpm_top (
  input  wire logic       I_MCLK,
  input  wire logic       I_NRST,
  input  wire logic       I_WR_EN,
  input  wire logic       I_RD_EN,
  input  wire logic [7:0] I_ADDR,
  input  wire logic [7:0] I_WDATA,
  input  wire logic [7:0] I_FAULT_EVT,
  input  wire logic       I_RB_GLOBAL_DIS,
  input  wire logic       I_FAULT_HOLD_DIS,
  output logic      [7:0] O_RDATA,
  output logic      [3:0] O_RB_RUN,
  output logic      [3:0] O_RB_PULLDOWN,
  output logic            O_FAULT_N
);
  fpm_stat_if sif ();

  // pins from the analog side are asynchronous: two stages before use
  logic [7:0] evt_s1;
  logic [7:0] evt_s2;
  logic       dis_s1;
  logic       dis_s2;
  logic       hold_s1;
  logic       hold_s2;

  logic [7:0] rb_cfg;
  logic [7:0] mask;
  logic [7:0] next_rb_cfg;
  logic [7:0] next_mask;
  logic [7:0] rdata;
  logic [7:0] next_rdata;
  logic [3:0] rb_run;
  logic [3:0] next_rb_run;
  logic [3:0] rb_pd;
  logic [3:0] next_rb_pd;
  logic       fault_n;
  logic       next_fault_n;
  logic       rd_stat;

  always_ff @(posedge I_MCLK or negedge I_NRST) begin
    if (!I_NRST) begin
      evt_s1  <= fpm_pkg::ZERO8;
      evt_s2  <= fpm_pkg::ZERO8;
      dis_s1  <= 1'b0;
      dis_s2  <= 1'b0;
      hold_s1 <= 1'b0;
      hold_s2 <= 1'b0;
    end else begin
      evt_s1  <= I_FAULT_EVT;
      evt_s2  <= evt_s1;
      dis_s1  <= I_RB_GLOBAL_DIS;
      dis_s2  <= dis_s1;
      hold_s1 <= I_FAULT_HOLD_DIS;
      hold_s2 <= hold_s1;
    end
  end

  assign rd_stat          = I_RD_EN && (I_ADDR == fpm_pkg::ADDR_FT_STAT);
  assign sif.fault_live   = evt_s2;
  assign sif.hold_disable = hold_s2;
  assign sif.read_clear   = rd_stat;

  fpm_status_hold u_hold (
    .I_MCLK (I_MCLK),
    .I_NRST (I_NRST),
    .sif    (sif)
  );

  // register writes
  always_comb begin
    next_rb_cfg = rb_cfg;
    next_mask   = mask;
    if (I_WR_EN) begin
      case (I_ADDR)
        fpm_pkg::ADDR_RB_CFG: next_rb_cfg = I_WDATA & fpm_pkg::RB_CFG_WMASK;
        fpm_pkg::ADDR_MASK:   next_mask   = I_WDATA;
        default:              next_mask   = mask;
      endcase
    end
  end

  // register reads; unmapped addresses read zero
  always_comb begin
    next_rdata = rdata;
    if (I_RD_EN) begin
      case (I_ADDR)
        fpm_pkg::ADDR_RB_CFG:  next_rdata = rb_cfg;
        fpm_pkg::ADDR_MASK:    next_rdata = mask;
        fpm_pkg::ADDR_FT_STAT: next_rdata = sif.status;
        default:               next_rdata = fpm_pkg::ZERO8;
      endcase
    end
  end

  always_comb begin
    next_rb_run = fpm_pkg::ZERO4;
    next_rb_pd  = fpm_pkg::ZERO4;
    if (!dis_s2) begin
      next_rb_run = rb_cfg[3:0];
      next_rb_pd  = ~rb_cfg[3:0];
    end
  end

  always_comb begin
    next_fault_n = ~|(sif.status & ~mask);
  end

  always_ff @(posedge I_MCLK or negedge I_NRST) begin
    if (!I_NRST) begin
      rb_cfg  <= fpm_pkg::RST_RB_CFG;
      mask    <= fpm_pkg::RST_MASK;
      rdata   <= fpm_pkg::ZERO8;
      rb_run  <= fpm_pkg::ZERO4;
      rb_pd   <= fpm_pkg::ZERO4;
      fault_n <= 1'b1;
    end else begin
      rb_cfg  <= next_rb_cfg;
      mask    <= next_mask;
      rdata   <= next_rdata;
      rb_run  <= next_rb_run;
      rb_pd   <= next_rb_pd;
      fault_n <= next_fault_n;
    end
  end

  assign O_RDATA       = rdata;
  assign O_RB_RUN      = rb_run;
  assign O_RB_PULLDOWN = rb_pd;
  assign O_FAULT_N     = fault_n;

  a_rb_run_sel: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
    !dis_s2 |=> (O_RB_RUN == $past(rb_cfg[3:0])))
    else $error("reverse block run does not follow select");
  a_rb_pulldown: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
    !dis_s2 |=> (O_RB_PULLDOWN == ~$past(rb_cfg[3:0])))
    else $error("pulldown does not follow cleared select");
  a_rb_reserved: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
    rb_cfg[7:4] == fpm_pkg::ZERO4)
    else $error("reserved config bits set");
  a_mask_write: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
    (I_WR_EN && I_ADDR == fpm_pkg::ADDR_MASK) |=> (mask == $past(I_WDATA)))
    else $error("mask write lost");
  a_pin_unmasked: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
    |(sif.status & ~mask) |=> !O_FAULT_N)
    else $error("unmasked fault not on pin");
  a_pin_release: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
    ((sif.status & ~mask) == fpm_pkg::ZERO8) |=> O_FAULT_N)
    else $error("pin held with only masked faults");
  a_spi_masked: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
    (mask[fpm_pkg::BIT_SPI_ERR] && sif.status == 8'h80) |=> O_FAULT_N)
    else $error("masked bus error drove pin");
  a_stat_read: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
    rd_stat |=> (O_RDATA == $past(sif.status)))
    else $error("status read ignores recorded error");

  c_fault_pin: cover property (@(posedge I_MCLK) disable iff (!I_NRST) $fell(O_FAULT_N));
  c_masked_evt: cover property (@(posedge I_MCLK) disable iff (!I_NRST)
    (|sif.status) && O_FAULT_N);
  c_rb_write: cover property (@(posedge I_MCLK) disable iff (!I_NRST)
    I_WR_EN && I_ADDR == fpm_pkg::ADDR_RB_CFG);
endmodule // fpm_top

/* test/fpm_host.sv */
// partner model: host register master issuing single byte writes and reads
`timescale 1ns/10ps
module fpm_host (
  input  wire logic       i_clk,
  input  wire logic [7:0] i_rdata,
  output logic            o_wr_en,
  output logic            o_rd_en,
  output logic      [7:0] o_addr,
  output logic      [7:0] o_wdata
);
  initial begin
    o_wr_en = 1'b0;
    o_rd_en = 1'b0;
    o_addr  = 8'h00;
    o_wdata = 8'h00;
  end
  // entered just after a rising edge; request is taken on the next edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    o_addr  = a;
    o_wdata = d;
    o_wr_en = 1'b1;
    @(posedge i_clk);
    #1;
    o_wr_en = 1'b0;
    // released lines never keep a stale value
    o_wdata = ~d;
    o_addr  = ~a;
    // one idle edge so a following call never re-drives a line in this time step
    @(posedge i_clk);
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    o_addr  = a;
    o_rd_en = 1'b1;
    @(posedge i_clk);
    #1;
    o_rd_en = 1'b0;
    o_addr  = ~a;
    d       = i_rdata;
    @(posedge i_clk);
    #1;
  endtask
endmodule // fpm_host

/* test/fault_pin_mask_and_reverse_block_cfg_test.sv */
// testbench: register access, reverse block outputs and fault pin masking
`timescale 1ns/10ps
module fault_pin_mask_and_reverse_block_cfg_test;
  logic       clk, nrst, wr_en, rd_en, gdis, hdis, fault_n;
  logic [7:0] addr, wdata, evt, rdata, d;
  logic [3:0] run, pd;
  int         n_fail, n_checks;
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  fpm_top i_dut (.I_MCLK(clk), .I_NRST(nrst), .I_WR_EN(wr_en), .I_RD_EN(rd_en),
    .I_ADDR(addr), .I_WDATA(wdata), .I_FAULT_EVT(evt), .I_RB_GLOBAL_DIS(gdis),
    .I_FAULT_HOLD_DIS(hdis), .O_RDATA(rdata), .O_RB_RUN(run), .O_RB_PULLDOWN(pd),
    .O_FAULT_N(fault_n));
  fpm_host i_host (.i_clk(clk), .i_rdata(rdata), .o_wr_en(wr_en), .o_rd_en(rd_en),
    .o_addr(addr), .o_wdata(wdata));
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic test_config;
    i_host.rd(fpm_pkg::ADDR_RB_CFG, d);
    chk(d, 8'h0F);
    chk({run, pd}, 8'hF0);
    i_host.rd(fpm_pkg::ADDR_MASK, d);
    chk(d, 8'h00);
    i_host.wr(fpm_pkg::ADDR_RB_CFG, 8'hA5);
    i_host.rd(fpm_pkg::ADDR_RB_CFG, d);
    chk(d, 8'h05);
    cyc(1);
    chk({run, pd}, 8'h5A);
    // global disable passes a sync, so allow a few edges
    gdis = 1'b1;
    cyc(4);
    chk({run, pd}, 8'h00);
    gdis = 1'b0;
    i_host.rd(8'h30, d);
    chk(d, 8'h00);
    $display("test config done");
  endtask
  task automatic test_mask;
    logic [7:0] b;
    for (int i = 0; i < 8; i++) begin
      b = 8'h01 << i;
      evt = b;
      cyc(6);
      chk({7'h0, fault_n}, 8'h00);
      i_host.wr(fpm_pkg::ADDR_MASK, b);
      cyc(4);
      chk({7'h0, fault_n}, 8'h01);
      i_host.rd(fpm_pkg::ADDR_FT_STAT, d);
      chk(d, b);
      evt = 8'h00;
      cyc(4);
      i_host.wr(fpm_pkg::ADDR_MASK, 8'h00);
      cyc(4);
      chk({7'h0, fault_n}, 8'h00);
      i_host.rd(fpm_pkg::ADDR_FT_STAT, d);
      chk(d, b);
      cyc(4);
      chk({7'h0, fault_n}, 8'h01);
      i_host.rd(fpm_pkg::ADDR_FT_STAT, d);
      chk(d, 8'h00);
    end
    $display("test mask done");
  endtask
  task automatic test_live;
    hdis = 1'b1;
    evt = 8'h10;
    cyc(6);
    chk({7'h0, fault_n}, 8'h00);
    evt = 8'h00;
    cyc(6);
    chk({7'h0, fault_n}, 8'h01);
    i_host.rd(fpm_pkg::ADDR_FT_STAT, d);
    chk(d, 8'h00);
    $display("test live done");
  endtask
  initial begin
    n_fail = 0;
    n_checks = 0;
    nrst = 1'b0;
    evt = 8'h00;
    gdis = 1'b0;
    hdis = 1'b0;
    repeat (16) @(posedge clk);
    #1;
    nrst = 1'b1;
    cyc(1);
    test_config();
    test_mask();
    test_live();
    print_verdict();
  end
  // whole run is well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    n_fail++;
    print_verdict();
  end
endmodule // fault_pin_mask_and_reverse_block_cfg_test
